// ==== inc/ldo_cfg_defs.vh ====
`ifndef LDO_CFG_DEFS_VH
`define LDO_CFG_DEFS_VH

// Regulator count and code widths
`define NUM_LDO 10
`define VCODE_W 6
`define TCODE_W 7
`define TCODE_MAX 7'h47
// Index of the narrow-range regulators and of the paired pair
`define NARROW_A 3
`define NARROW_B 4
`define LDO_EIGHT 8
`define LDO_NINE 9
// Codes in millivolts: wide 1000 + 50*n, narrow 1000 + 25*n (max 19)
`define WIDE_BASE_MV 12'h3E8
`define WIDE_STEP_MV 12'h032
`define WIDE_MAX_CODE 6'h2F
`define NARROW_BASE_MV 12'h3E8
`define NARROW_STEP_MV 12'h019
`define NARROW_MAX_CODE 6'h13
// Tracking code in units of 0.1 mV: 6000 + 125*n
`define TRK_BASE_DMV 16'h1770
`define TRK_STEP_DMV 16'h007D
// Values of a bit in the per-regulator select vectors
`define SRC_SEQ 1'b0
`define SRC_PIN 1'b1

`endif

// ==== rtl/ldo_config_control.v ====
// Functional notes
// - Regulators 0-2,5-9 map code to 1V..3.35V
// - Regulators 3,4 map code to 1V..1.475V
// - Select bit 1 uses pin, else sequencer/software
// - Pin choice 0 picks input a, 1 b
// - Pin choice ignored unless select bit set
// - Regulator nine copies eight until software writes
// - Tracking active only with enable and power-good
// - Tracking code 0.6V plus 12.5mV steps to 71
// - Short-circuit status follows over-current, no latch
`timescale 1ns/1ns
`include "ldo_cfg_defs.vh"

module ldo_config_control (
    input wire ref_clk,
    input wire rstn,
    input wire [`NUM_LDO*`VCODE_W-1:0] regulator_voltage_code,
    input wire nine_code_write,
    input wire [`NUM_LDO-1:0] pin_enable_select,
    input wire [`NUM_LDO-1:0] pin_choice,
    input wire power_enable_input_a,
    input wire power_enable_input_b,
    input wire [`NUM_LDO-1:0] software_on_bits,
    input wire [`NUM_LDO-1:0] sequencer_on,
    input wire off_state_start,
    input wire [`TCODE_W-1:0] tracking_voltage_code,
    input wire tracking_enable,
    input wire tracking_source_select,
    input wire [`TCODE_W-1:0] cpu_converter_code,
    input wire [`TCODE_W-1:0] soc_converter_code,
    input wire cpu_converter_pgood,
    input wire soc_converter_pgood,
    input wire [`NUM_LDO:0] over_current,
    output reg [`NUM_LDO-1:0] regulator_on_r,
    output reg [`NUM_LDO*12-1:0] regulator_target_mv_r,
    output reg [`TCODE_W-1:0] tracking_code_r,
    output reg [15:0] tracking_target_dmv_r,
    output reg tracking_active_r,
    output reg [`NUM_LDO:0] short_circuit_status_r
);

// ----------------------------------------------------------------
// Code conversion
// ----------------------------------------------------------------
function [11:0] ldo_mv;
    input [`VCODE_W-1:0] code;
    input narrow;
    reg [`VCODE_W-1:0] c;
    begin
        if (narrow) begin
            c = (code > `NARROW_MAX_CODE) ? `NARROW_MAX_CODE : code;
            ldo_mv = `NARROW_BASE_MV + c * `NARROW_STEP_MV;
        end else begin
            c = (code > `WIDE_MAX_CODE) ? `WIDE_MAX_CODE : code;
            ldo_mv = `WIDE_BASE_MV + c * `WIDE_STEP_MV;
        end
    end
endfunction

function [15:0] trk_dmv;
    input [`TCODE_W-1:0] code;
    begin
        trk_dmv = `TRK_BASE_DMV + code * `TRK_STEP_DMV;
    end
endfunction

function [`TCODE_W-1:0] trk_clamp;
    input [`TCODE_W-1:0] code;
    begin
        trk_clamp = (code > `TCODE_MAX) ? `TCODE_MAX : code;
    end
endfunction

function pin_level_of;
    input choice;
    input level_a;
    input level_b;
    begin
        // Choice only matters when the pin source is selected
        pin_level_of = choice ? level_b : level_a;
    end
endfunction

function enable_of;
    input select;
    input choice;
    input level_a;
    input level_b;
    input seq_on;
    input sw_on;
    begin
        if (select == `SRC_PIN)
            enable_of = pin_level_of(choice, level_a, level_b);
        else
            enable_of = seq_on | sw_on;
    end
endfunction

function is_narrow;
    input integer idx;
    begin
        is_narrow = (idx == `NARROW_A) || (idx == `NARROW_B);
    end
endfunction

// ----------------------------------------------------------------
// Regulator nine follows eight after a cold start
// ----------------------------------------------------------------
reg nine_own_r;
reg nine_own_nxt;

always @* begin
    nine_own_nxt = nine_own_r;
    if (off_state_start)
        nine_own_nxt = 1'b0;
    if (nine_code_write)
        nine_own_nxt = 1'b1;
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
        nine_own_r <= 1'b0;
    else
        nine_own_r <= nine_own_nxt;
end

// ----------------------------------------------------------------
// Enable source
// ----------------------------------------------------------------
reg [`NUM_LDO-1:0] on_nxt;
integer i;

always @* begin
    on_nxt = {`NUM_LDO{1'b0}};
    for (i = 0; i < `NUM_LDO; i = i + 1) begin
        on_nxt[i] = enable_of(pin_enable_select[i], pin_choice[i],
                              power_enable_input_a, power_enable_input_b,
                              sequencer_on[i],
                              software_on_bits[i]);
    end
end

// ----------------------------------------------------------------
// Voltage targets
// ----------------------------------------------------------------
reg [`NUM_LDO*12-1:0] mv_nxt;
reg [`VCODE_W-1:0] code_sel;
integer j;

always @* begin
    mv_nxt = {`NUM_LDO*12{1'b0}};
    code_sel = {`VCODE_W{1'b0}};
    for (j = 0; j < `NUM_LDO; j = j + 1) begin
        code_sel = regulator_voltage_code[j*`VCODE_W +: `VCODE_W];
        if (j == `LDO_NINE && !nine_own_r)
            code_sel = regulator_voltage_code[`LDO_EIGHT*`VCODE_W +:
                                              `VCODE_W];
        mv_nxt[j*12 +: 12] = ldo_mv(code_sel, is_narrow(j));
    end
end

// ----------------------------------------------------------------
// Tracking regulator
// ----------------------------------------------------------------
reg trk_pgood;
reg trk_act;
reg [`TCODE_W-1:0] conv_code;
reg [`TCODE_W-1:0] trk_code_nxt;
reg [15:0] trk_dmv_nxt;

always @* begin
    trk_pgood = tracking_source_select ? soc_converter_pgood
                                       : cpu_converter_pgood;
    trk_act = tracking_enable & trk_pgood;
    conv_code = tracking_source_select ? soc_converter_code
                                       : cpu_converter_code;
    // An in-range converter code passes unchanged: no offset is added
    if (trk_act)
        trk_code_nxt = trk_clamp(conv_code);
    else
        trk_code_nxt = trk_clamp(tracking_voltage_code);
    trk_dmv_nxt = trk_dmv(trk_code_nxt);
end

// ----------------------------------------------------------------
// Enable and voltage registers
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        regulator_on_r <= {`NUM_LDO{1'b0}};
        regulator_target_mv_r <= {`NUM_LDO*12{1'b0}};
    end else begin
        regulator_on_r <= on_nxt;
        regulator_target_mv_r <= mv_nxt;
    end
end

// ----------------------------------------------------------------
// Tracking registers
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        tracking_code_r <= {`TCODE_W{1'b0}};
        tracking_target_dmv_r <= 16'h0000;
        tracking_active_r <= 1'b0;
    end else begin
        tracking_code_r <= trk_code_nxt;
        tracking_target_dmv_r <= trk_dmv_nxt;
        tracking_active_r <= trk_act;
    end
end

// ----------------------------------------------------------------
// Short-circuit status
// ----------------------------------------------------------------
// A fresh copy every cycle, so a bit clears itself when the fault ends
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
        short_circuit_status_r <= {(`NUM_LDO+1){1'b0}};
    else
        short_circuit_status_r <= over_current;
end

endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/1ns
module host_model (
    input wire ref_clk,
    output reg power_enable_input_a = 1'b0,
    output reg power_enable_input_b = 1'b0,
    output reg [6:0] cpu_converter_code = 7'h00,
    output reg [6:0] soc_converter_code = 7'h00
);
    reg [3:0] cnt_r = 4'h0;
    // Codes stay at or below 61, inside the tracking range
    always @(negedge ref_clk) begin
        cnt_r <= cnt_r + 4'h1;
        power_enable_input_a <= cnt_r[0] ^ cnt_r[3];
        power_enable_input_b <= cnt_r[1];
        cpu_converter_code <= {1'b0, cnt_r[2:0], 3'h5};
        soc_converter_code <= {1'b0, cnt_r[3:1], 3'h2};
    end
endmodule

// ==== verification/ldo_cfg_sva.sv ====
`timescale 1ns/1ns
module ldo_cfg_sva (
    input wire ref_clk, rstn, off_state_start, nine_code_write,
    input wire power_enable_input_a, power_enable_input_b,
    input wire tracking_enable, tracking_source_select, tracking_active_r,
    input wire cpu_converter_pgood, soc_converter_pgood,
    input wire [119:0] regulator_target_mv_r,
    input wire [9:0] pin_enable_select, pin_choice, regulator_on_r,
    input wire [9:0] software_on_bits, sequencer_on,
    input wire [10:0] over_current, short_circuit_status_r,
    input wire [6:0] tracking_voltage_code, tracking_code_r,
    input wire [6:0] cpu_converter_code, soc_converter_code,
    input wire [15:0] tracking_target_dmv_r
);
    reg up_r;
    wire sel = tracking_source_select;
    wire pg = sel ? soc_converter_pgood : cpu_converter_pgood;
    wire pin5 = pin_choice[5] ? power_enable_input_b : power_enable_input_a;
    wire [6:0] tv = tracking_voltage_code;
    wire [9:0] pin_lvl = (pin_choice & {10{power_enable_input_b}}) |
        (~pin_choice & {10{power_enable_input_a}});
    // Outputs are only meaningful once the first edge after reset loaded them
    always @(posedge ref_clk or negedge rstn)
        if (!rstn) up_r <= 1'b0;
        else up_r <= 1'b1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_start;
        off_state_start && !nine_code_write ##1 !nine_code_write;
    endsequence
    AST_SC: assert property (up_r |-> short_circuit_status_r ==
        $past(over_current)) else $error("status");
    AST_PIN: assert property (up_r && $past(pin_enable_select[5]) |->
        regulator_on_r[5] == $past(pin5)) else $error("pin enable");
    AST_SEQ: assert property (up_r && !$past(pin_enable_select[5]) |->
        regulator_on_r[5] == $past(software_on_bits[5] | sequencer_on[5]))
        else $error("seq enable");
    AST_ON: assert property (up_r |-> regulator_on_r ==
        $past((pin_enable_select & pin_lvl) |
        (~pin_enable_select & (software_on_bits | sequencer_on))))
        else $error("enable vector");
    AST_TACT: assert property (up_r |-> tracking_active_r ==
        $past(tracking_enable && pg)) else $error("track active");
    AST_TSRC: assert property (up_r && tracking_active_r |->
        tracking_code_r == $past(sel ? soc_converter_code : cpu_converter_code))
        else $error("track source");
    AST_CLAMP: assert property (up_r && !tracking_active_r |->
        tracking_code_r == ($past(tv) > 7'h47 ? 7'h47 : $past(tv)))
        else $error("clamp");
    AST_DMV: assert property (up_r |-> tracking_target_dmv_r ==
        16'h1770 + 16'h007D * tracking_code_r) else $error("dmv");
    AST_NINE: assert property (s_start |=>
        regulator_target_mv_r[119:108] == regulator_target_mv_r[107:96])
        else $error("nine copy");
endmodule
bind ldo_config_control ldo_cfg_sva i_ldo_cfg_sva (.*);

// ==== verification/ldo_config_control_bench.sv ====
`timescale 1ns/1ns
module ldo_config_control_bench;
    reg ref_clk = 1'b0, rstn = 1'b0, off_state_start = 1'b0;
    reg nine_code_write = 1'b0, tracking_enable = 1'b0;
    reg tracking_source_select = 1'b0;
    reg cpu_converter_pgood = 1'b0, soc_converter_pgood = 1'b0;
    reg [59:0] regulator_voltage_code = 60'h0;
    reg [9:0] pin_enable_select = 10'h0, pin_choice = 10'h0;
    reg [9:0] software_on_bits = 10'h0, sequencer_on = 10'h0;
    reg [6:0] tracking_voltage_code = 7'h00;
    reg [10:0] over_current = 11'h000;
    wire power_enable_input_a, power_enable_input_b, tracking_active_r;
    wire [6:0] cpu_converter_code, soc_converter_code, tracking_code_r;
    wire [9:0] regulator_on_r;
    wire [119:0] regulator_target_mv_r;
    wire [15:0] tracking_target_dmv_r;
    wire [10:0] short_circuit_status_r;
    integer seed = 32'hA90511CC, n_fail = 0, num_checks = 0, cyc = 0, i;
    reg [119:0] q[$];
    reg [119:0] e;
    reg [99:0] r;
    reg [9:0] m;
    reg [5:0] c;
    reg own9 = 1'b0;
    ldo_config_control i_ldo_config_control (.*);
    host_model i_host_model (.*);
    task check(input [119:0] seen, input [119:0] want);
        num_checks = num_checks + 1;
        if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t targets %h", $time, seen);
        end
    endtask
    task finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        #102 rstn = 1'b1;
        repeat (2000) @(posedge ref_clk);
        finish_test;
    end
    always @(negedge ref_clk) if (rstn) begin
        r = 100'({$random(seed), $random(seed), $random(seed),
            $random(seed)});
        // Nine stays off until its own code has been written
        m = own9 ? 10'h3FF : 10'h1FF;
        regulator_voltage_code = r[99:40];
        pin_enable_select = r[39:30] & m;
        pin_choice = r[29:20];
        software_on_bits = r[19:10] & m;
        sequencer_on = r[9:0] & m;
        {tracking_voltage_code, tracking_enable, tracking_source_select,
            cpu_converter_pgood, soc_converter_pgood, over_current,
            off_state_start, nine_code_write} = 24'($random(seed));
        for (i = 0; i < 10; i = i + 1) begin
            c = regulator_voltage_code[(i == 9 && !own9 ? 8 : i)*6+:6];
            if (i == 3 || i == 4)
                e[i*12+:12] = 12'h3E8 + 12'h019 * (c > 6'h13 ? 6'h13 : c);
            else
                e[i*12+:12] = 12'h3E8 + 12'h032 * (c > 6'h2F ? 6'h2F : c);
        end
        q.push_back(e);
        if (nine_code_write)
            own9 = 1'b1;
        else if (off_state_start)
            own9 = 1'b0;
    end
    always @(posedge ref_clk) if (q.size() > 0) begin
        #1 check(regulator_target_mv_r, q.pop_front());
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            finish_test;
        end
    end
endmodule
